// >>> verilog/dpu_ctl.sv
/*
  Controller end: APB register slave, ck divider and the start-up
  sequencer, then single commands ordered by software.
  Assumes the memory end samples the link on ck rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module dpu_ctl #(
  parameter int unsigned PWR_WAIT = dpu_pkg::PWR_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dpu_link_if.ctl link
);
  import dpu_pkg::*;

  typedef enum logic [3:0] {
    C_IDLE = 4'h0, C_PWR = 4'h1, C_CKE = 4'h3, C_PRE1 = 4'h2, C_E2 = 4'h6,
    C_E3 = 4'h7, C_E1 = 4'h5, C_MRR = 4'h4, C_PRE2 = 4'hc, C_REF = 4'hd,
    C_MRS = 4'hf, C_WDLL = 4'he, C_OCDD = 4'ha, C_OCDX = 4'hb, C_RUN = 4'h9,
    C_ISSUE = 4'h8
  } dpu_cstate_type;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] ctrl_q;
  logic [12:0] mode_q, emr_q;
  logic [17:0] cmd_q;
  logic pend_q, err_q, start_q, done_q;
  dpu_cstate_type st_q;
  wire logic acc = psel & penable & pready;
  wire logic wr = acc & pwrite;
  wire logic hit = paddr == REG_CTRL || paddr == REG_MODE || paddr == REG_EMR
                   || paddr == REG_CMD || paddr == REG_STAT;
  logic cmd_bad;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable) begin
        unique case (paddr)
          REG_CTRL: prdata <= {28'h0, ctrl_q};
          REG_MODE: prdata <= {19'h0, mode_q};
          REG_EMR: prdata <= {19'h0, emr_q};
          REG_CMD: prdata <= {14'h0, cmd_q};
          REG_STAT: prdata <= {28'h0, pend_q, err_q, done_q, st_q != C_IDLE && !done_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= 4'h0;
      mode_q <= MODE_RESET;
      emr_q <= EMR_RESET;
      cmd_q <= 18'h0;
      start_q <= 1'b0;
      pend_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      start_q <= wr && paddr == REG_CTRL && pwdata[CTRL_START];
      if (wr && paddr == REG_CTRL) ctrl_q <= {pwdata[3:1], 1'b0};
      if (wr && paddr == REG_MODE) mode_q <= pwdata[12:0];
      if (wr && paddr == REG_EMR) emr_q <= pwdata[12:0];
      if (wr && paddr == REG_CMD && !pend_q && done_q) cmd_q <= pwdata[17:0];
      // Orders written before the start-up sequence sets done_q are refused
      if (wr && paddr == REG_CMD && !pend_q && done_q)
        pend_q <= 1'b1;
      else if (st_q == C_ISSUE && ck_fall && !sent_q)
        pend_q <= 1'b0;
      // A new error wins over a clear in the same cycle
      if (cmd_bad || (wr && paddr == REG_CMD && !done_q))
        err_q <= 1'b1;
      else if (wr && paddr == REG_STAT && pwdata[STAT_ERR])
        err_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Link clock
  // ----------------------------------------
  logic [2:0] div_q;
  logic ck_fall;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_q <= 3'h0;
      link.ck <= 1'b0;
      link.ck_n <= 1'b1;
    end else begin
      div_q <= div_q + 3'h1;
      if (div_q == CK_HALF_LAST) begin
        link.ck <= ~link.ck;
        link.ck_n <= link.ck;
      end
    end
  end
  assign ck_fall = div_q == CK_HALF_LAST && link.ck;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [14:0] wait_q;
  logic [7:0] dll_q;
  logic [1:0] ref_q;
  logic [3:0] open_q;
  logic sent_q, swap_q;
  logic [3:0] cmd_c;
  logic [1:0] ba_c;
  logic [12:0] a_c;
  dpu_cstate_type nx_c;
  wire logic [2:0] op = cmd_q[CMD_OP_LSB+:3];
  wire logic [1:0] op_ba = cmd_q[14:13];
  wire logic [12:0] emr_run = {emr_q[12:11], ctrl_q[CTRL_SE], emr_q[9:0]};

  always_comb begin
    cmd_c = CMD_NOP;
    ba_c = 2'h0;
    a_c = 13'h0;
    nx_c = st_q;
    cmd_bad = 1'b0;
    unique case (st_q)
      C_PRE1: begin cmd_c = CMD_PRE; a_c[A_PRE_ALL] = 1'b1; nx_c = swap_q ? C_E1 : C_E2; end
      C_E2: begin cmd_c = CMD_MRS; ba_c = BA_EMR2; nx_c = C_E3; end
      C_E3: begin cmd_c = CMD_MRS; ba_c = BA_EMR3; nx_c = swap_q ? C_PRE2 : C_E1; end
      C_E1: begin
        cmd_c = CMD_MRS;
        ba_c = BA_EMR1;
        a_c = emr_run;
        a_c[A_DLL_OFF] = 1'b0;
        a_c[A_OCD_LSB+:3] = OCD_EXIT;
        nx_c = C_MRR;
      end
      C_MRR: begin
        cmd_c = CMD_MRS;
        a_c = mode_q;
        a_c[A_DLL_RST] = 1'b1;
        nx_c = swap_q ? C_E2 : C_PRE2;
      end
      C_PRE2: begin cmd_c = CMD_PRE; a_c[A_PRE_ALL] = 1'b1; nx_c = C_REF; end
      C_REF: begin cmd_c = CMD_REF; nx_c = ref_q == 2'h2 ? C_MRS : C_REF; end
      C_MRS: begin
        cmd_c = CMD_MRS;
        a_c = mode_q;
        a_c[A_DLL_RST] = 1'b0;
        nx_c = C_WDLL;
      end
      C_OCDD, C_OCDX: begin
        cmd_c = CMD_MRS;
        ba_c = BA_EMR1;
        a_c = emr_run;
        a_c[A_DLL_OFF] = 1'b0;
        a_c[A_OCD_LSB+:3] = st_q == C_OCDD ? OCD_DEFAULT : OCD_EXIT;
        nx_c = st_q == C_OCDD ? C_OCDX : C_RUN;
      end
      C_ISSUE: begin
        ba_c = op_ba;
        a_c = cmd_q[12:0];
        nx_c = C_RUN;
        unique case (op)
          OP_ACT: cmd_c = CMD_ACT;
          OP_RD: cmd_c = open_q[op_ba] ? CMD_RD : CMD_NOP;
          OP_WR: cmd_c = open_q[op_ba] ? CMD_WR : CMD_NOP;
          OP_PRE: cmd_c = CMD_PRE;
          OP_REF: cmd_c = open_q == 4'h0 ? CMD_REF : CMD_NOP;
          default: cmd_c = CMD_NOP;
        endcase
        cmd_bad = cmd_c == CMD_NOP && !sent_q && ck_fall;
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= C_IDLE;
      done_q <= 1'b0;
      sent_q <= 1'b0;
      swap_q <= 1'b0;
      wait_q <= 15'h0;
      dll_q <= 8'h0;
      ref_q <= 2'h0;
      open_q <= 4'h0;
      link.cke <= 1'b0;
      link.odt <= 1'b0;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
      link.ba <= 2'h0;
      link.addr <= 13'h0;
    end else begin
      link.odt <= done_q & ctrl_q[CTRL_ODT];
      if (ck_fall && dll_q != DLL_CK) dll_q <= dll_q + 8'h1;
      unique case (st_q)
        C_IDLE: if (start_q) begin
          st_q <= C_PWR;
          swap_q <= ctrl_q[CTRL_SWAP];
          wait_q <= 15'h0;
        end
        C_PWR: begin
          if (wait_q < 15'(PWR_WAIT)) wait_q <= wait_q + 15'h1;
          else if (ck_fall) begin
            link.cke <= 1'b1;
            wait_q <= 15'h0;
            st_q <= C_CKE;
          end
        end
        C_CKE: begin
          if (wait_q < 15'(CKE_CYC)) wait_q <= wait_q + 15'h1;
          else st_q <= C_PRE1;
        end
        C_WDLL: if (dll_q == DLL_CK) st_q <= C_OCDD;
        C_RUN: begin
          done_q <= 1'b1;
          if (pend_q) st_q <= C_ISSUE;
        end
        default: if (ck_fall) begin
          // One ck of command, one ck of NOP: covers the mode write cycle time
          if (!sent_q) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= cmd_c;
            link.ba <= ba_c;
            link.addr <= a_c;
            sent_q <= 1'b1;
            if (st_q == C_MRR) dll_q <= 8'h0;
            if (st_q == C_REF) ref_q <= ref_q + 2'h1;
            if (st_q == C_ISSUE && cmd_c == CMD_ACT) open_q[op_ba] <= 1'b1;
            if (st_q == C_ISSUE && cmd_c == CMD_PRE)
              open_q <= cmd_q[A_PRE_ALL] ? 4'h0 : open_q & ~(4'h1 << op_ba);
            if ((cmd_c == CMD_RD || cmd_c == CMD_WR) && cmd_q[A_PRE_ALL])
              open_q[op_ba] <= 1'b0;
          end else begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
            sent_q <= 1'b0;
            st_q <= nx_c;
            if (st_q == C_E3 && swap_q && nx_c == C_PRE2) swap_q <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> include/dpu_pkg.sv
/*
  Shared constants for the memory power-up link: timing, command codes,
  address bit positions and controller register map.
  Assumes a 100 MHz core clock on both ends.
*/
package dpu_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_PWR_US = 200;
  localparam int unsigned T_CKE_NS = 400;
  localparam int unsigned PWR_CYC = (T_PWR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CKE_CYC = (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DLL_CK = 8'd200;
  localparam logic [1:0] MIN_REF = 2'd2;
  localparam logic [2:0] CK_HALF_LAST = 3'h7;
  // ----------------------------------------
  // Commands {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;
  localparam logic [1:0] BA_EMR2 = 2'h2;
  localparam logic [1:0] BA_EMR3 = 2'h3;
  // ----------------------------------------
  // Address bit positions
  // ----------------------------------------
  localparam int unsigned A_DLL_OFF = 0;
  localparam int unsigned A_BT = 3;
  localparam int unsigned A_OCD_LSB = 7;
  localparam int unsigned A_DLL_RST = 8;
  localparam int unsigned A_PRE_ALL = 10;
  localparam int unsigned A_SE_DQS = 10;
  localparam logic [2:0] BL4 = 3'h2;
  localparam logic [2:0] BL8 = 3'h3;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  // ----------------------------------------
  // Controller registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_EMR = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_SWAP = 1;
  localparam int unsigned CTRL_SE = 2;
  localparam int unsigned CTRL_ODT = 3;
  localparam int unsigned CMD_OP_LSB = 15;
  localparam int unsigned STAT_ERR = 2;
  localparam logic [12:0] MODE_RESET = 13'h0232;
  localparam logic [12:0] EMR_RESET = 13'h0000;
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_RD = 3'h2;
  localparam logic [2:0] OP_WR = 3'h3;
  localparam logic [2:0] OP_PRE = 3'h4;
  localparam logic [2:0] OP_REF = 3'h5;
endpackage

// >>> include/dpu_link_if.sv
/*
  Command/address link between controller and memory end.
  Assumes both ends share core_clk; ck is a divided clock carried as data.
*/
`timescale 1ns/1ns
`default_nettype none
interface dpu_link_if;
  logic ck;
  logic ck_n;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  logic odt;
  modport ctl (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
  modport mem (input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface
`default_nettype wire

// >>> verilog/dpu_mem.sv
/*
  Memory end: samples the link on ck rising edges, follows the start-up
  order, keeps mode registers, open rows and burst progress.
  Assumes link pins are asynchronous to core_clk and ck is at most core/4.
*/
`timescale 1ns/1ns
`default_nettype none
module dpu_mem (
  input wire logic core_clk,
  input wire logic reset,
  dpu_link_if.mem link,
  output logic ready,
  output logic init_err,
  output logic strobe_diff,
  output logic burst_busy,
  output logic burst_wr,
  output logic [1:0] burst_bank,
  output logic [9:0] burst_col,
  output logic burst_ap
);
  import dpu_pkg::*;

  typedef enum logic [3:0] {
    M_CKE = 4'h0, M_PRE1 = 4'h1, M_E1 = 4'h3, M_MRR = 4'h2, M_PRE2 = 4'h6,
    M_REF = 4'h7, M_OCDD = 4'h5, M_OCDX = 4'h4, M_RDY = 4'hc
  } dpu_mstate_type;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [21:0] s1_q, s2_q;
  logic ck_s3_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_q <= 22'h0;
      s2_q <= 22'h0;
      ck_s3_q <= 1'b0;
    end else begin
      s1_q <= {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
               link.ba, link.addr, link.odt};
      s2_q <= s1_q;
      ck_s3_q <= s2_q[21];
    end
  end
  wire logic rise = s2_q[21] & ~ck_s3_q;
  wire logic edge_any = s2_q[21] ^ ck_s3_q;
  wire logic cke = s2_q[20];
  wire logic [3:0] cmd = s2_q[19:16];
  wire logic [1:0] ba = s2_q[15:14];
  wire logic [12:0] a = s2_q[13:1];
  wire logic odt = s2_q[0];
  wire logic live = rise & cke & (cmd != CMD_NOP) & ~cmd[3];

  // ----------------------------------------
  // Start-up order
  // ----------------------------------------
  dpu_mstate_type st_q;
  logic [12:0] mr_q, emr1_q;
  logic got2_q, got3_q;
  logic [1:0] ref_q;
  logic [7:0] dll_q;
  logic err_d;
  dpu_mstate_type st_d;
  always_comb begin
    st_d = st_q;
    err_d = 1'b0;
    if (st_q != M_RDY && odt)
      err_d = 1'b1;
    if (live) begin
      unique case (st_q)
        M_CKE, M_RDY: err_d = (st_q == M_CKE);
        M_PRE1: if (cmd == CMD_PRE && a[A_PRE_ALL]) st_d = M_E1; else err_d = 1'b1;
        M_E1: begin
          if (cmd == CMD_MRS && ba == BA_EMR2 && !got2_q) ;
          else if (cmd == CMD_MRS && ba == BA_EMR3 && got2_q && !got3_q) ;
          else if (cmd == CMD_MRS && ba == BA_EMR1 && !a[A_DLL_OFF]) st_d = M_MRR;
          else err_d = 1'b1;
        end
        M_MRR: if (cmd == CMD_MRS && ba == BA_MR && a[A_DLL_RST]) st_d = M_PRE2;
          else err_d = 1'b1;
        M_PRE2: begin
          if (cmd == CMD_MRS && ba == BA_EMR2 && !got2_q) ;
          else if (cmd == CMD_MRS && ba == BA_EMR3 && got2_q && !got3_q) ;
          else if (cmd == CMD_PRE && a[A_PRE_ALL] && got3_q) st_d = M_REF;
          else err_d = 1'b1;
        end
        M_REF: begin
          if (cmd == CMD_REF) ;
          else if (cmd == CMD_MRS && ba == BA_MR && !a[A_DLL_RST] && ref_q >= MIN_REF)
            st_d = M_OCDD;
          else err_d = 1'b1;
        end
        M_OCDD: if (cmd == CMD_MRS && ba == BA_EMR1 && dll_q == DLL_CK
                    && a[A_OCD_LSB+:3] == OCD_DEFAULT) st_d = M_OCDX;
          else err_d = 1'b1;
        M_OCDX: if (cmd == CMD_MRS && ba == BA_EMR1 && a[A_OCD_LSB+:3] == OCD_EXIT)
            st_d = M_RDY;
          else err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= M_CKE;
      init_err <= 1'b0;
      ready <= 1'b0;
    end else begin
      if (st_q == M_CKE && rise && cke)
        st_q <= M_PRE1;
      else
        st_q <= st_d;
      init_err <= init_err | err_d;
      ready <= (st_d == M_RDY);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      got2_q <= 1'b0;
      got3_q <= 1'b0;
      ref_q <= 2'h0;
      dll_q <= 8'h0;
      mr_q <= 13'h0;
      emr1_q <= 13'h0;
      strobe_diff <= 1'b1;
    end else begin
      if (live && cmd == CMD_MRS && ba == BA_EMR2) got2_q <= 1'b1;
      if (live && cmd == CMD_MRS && ba == BA_EMR3) got3_q <= 1'b1;
      if (live && cmd == CMD_REF && ref_q != 2'h3) ref_q <= ref_q + 2'h1;
      if (live && cmd == CMD_MRS && ba == BA_MR && a[A_DLL_RST])
        dll_q <= 8'h0;
      else if (rise && dll_q != DLL_CK)
        dll_q <= dll_q + 8'h1;
      if (live && cmd == CMD_MRS && ba == BA_MR) mr_q <= a;
      if (live && cmd == CMD_MRS && ba == BA_EMR1) begin
        emr1_q <= a;
        strobe_diff <= ~a[A_SE_DQS];
      end
    end
  end

  // ----------------------------------------
  // Rows and bursts
  // ----------------------------------------
  logic [3:0] open_q;
  logic [3:0] beat_q, len_q;
  logic [9:0] start_q;
  wire logic rdwr = live && ready && (cmd == CMD_RD || cmd == CMD_WR);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      open_q <= 4'h0;
    end else if (live && ready) begin
      if (cmd == CMD_ACT)
        open_q[ba] <= 1'b1;
      else if (cmd == CMD_PRE && a[A_PRE_ALL])
        open_q <= 4'h0;
      else if (cmd == CMD_PRE)
        open_q[ba] <= 1'b0;
      else if (rdwr && a[A_PRE_ALL])
        open_q[ba] <= 1'b0;
    end
  end

  // Bursts advance two beats per ck period, one on each edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      burst_busy <= 1'b0;
      burst_wr <= 1'b0;
      burst_bank <= 2'h0;
      burst_col <= 10'h0;
      burst_ap <= 1'b0;
      beat_q <= 4'h0;
      len_q <= 4'h4;
      start_q <= 10'h0;
    end else if (rdwr && open_q[ba]) begin
      burst_busy <= 1'b1;
      burst_wr <= (cmd == CMD_WR);
      burst_bank <= ba;
      burst_col <= a[9:0];
      burst_ap <= a[A_PRE_ALL];
      start_q <= a[9:0];
      beat_q <= 4'h1;
      len_q <= (mr_q[2:0] == BL8) ? 4'h8 : 4'h4;
    end else if (burst_busy && edge_any) begin
      if (beat_q == len_q) begin
        burst_busy <= 1'b0;
      end else begin
        beat_q <= beat_q + 4'h1;
        if (mr_q[A_BT])
          burst_col <= start_q ^ {7'h0, beat_q[2:0]};
        else if (len_q == 4'h8)
          burst_col <= {start_q[9:3], start_q[2:0] + beat_q[2:0]};
        else
          burst_col <= {start_q[9:2], start_q[1:0] + beat_q[1:0]};
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/dpu_assertions.sv
/*
  Link checker for the power-up command link between the two ends.
  Assumes it sees the interface signals directly, clocked by core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dpu_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ck,
  input wire logic ck_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic odt
);
  import dpu_pkg::*;
  logic [3:0] cmd;
  logic [3:0] cmd_q;
  logic cmd_start;
  logic [7:0] cke_cnt_q;
  logic [11:0] dll_cnt_q;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign cmd_start = (cmd != CMD_NOP) && (cmd_q == CMD_NOP);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) cmd_q <= CMD_NOP;
    else cmd_q <= cmd;
  end
  // Saturating, so a long run never wraps into a false fail
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) cke_cnt_q <= 8'h0;
    else if (!cke) cke_cnt_q <= 8'h0;
    else if (cke_cnt_q != 8'hff) cke_cnt_q <= cke_cnt_q + 8'h1;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) dll_cnt_q <= 12'h0;
    else if (cmd_start && cmd == CMD_MRS && ba == BA_MR && addr[A_DLL_RST]) dll_cnt_q <= 12'h1;
    else if (dll_cnt_q != 12'hfff) dll_cnt_q <= dll_cnt_q + 12'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_hold;
    $stable({cmd, ba, addr})[*8];
  endsequence
  sequence s_ocd(logic [2:0] v);
    cmd_start && cmd == CMD_MRS && ba == BA_EMR1 && addr[9:7] == v;
  endsequence
  property p_ck_pair; ck_n == !ck; endproperty
  property p_ck_runs; cke |-> ##[1:8] $changed(ck); endproperty
  property p_power_hold; !cke |-> !odt && cmd == CMD_NOP; endproperty
  property p_cke_stays; cke |=> cke; endproperty
  property p_nop_gap; cmd_start |-> cke_cnt_q >= 8'd40; endproperty
  property p_cmd_slot; cmd_start |=> s_hold ##8 (cmd == CMD_NOP); endproperty
  property p_addr_on_fall; $changed(addr) |-> !ck; endproperty
  property p_dll_on; cmd_start && cmd == CMD_MRS && ba == BA_EMR1 |-> !addr[A_DLL_OFF]; endproperty
  property p_dll_wait; s_ocd(OCD_DEFAULT) |-> dll_cnt_q >= 12'd3200; endproperty
  property p_ocd_exit; s_ocd(OCD_DEFAULT) |-> ##32 s_ocd(OCD_EXIT); endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("ck_n not inverse of ck");
  a_ck_runs: assert property (p_ck_runs) else $error("ck stalled");
  a_power_hold: assert property (p_power_hold) else $error("odt or command while cke low");
  a_cke_stays: assert property (p_cke_stays) else $error("cke dropped");
  a_nop_gap: assert property (p_nop_gap) else $error("command too soon after cke");
  a_cmd_slot: assert property (p_cmd_slot) else $error("command slot broken");
  a_addr_on_fall: assert property (p_addr_on_fall) else $error("address moved with ck high");
  a_dll_on: assert property (p_dll_on) else $error("register one write with DLL off");
  a_dll_wait: assert property (p_dll_wait) else $error("calibration too early");
  a_ocd_exit: assert property (p_ocd_exit) else $error("calibration exit missing");
endmodule
`default_nettype wire

// >>> verification/dpu_bench.sv
/*
  Bench joining controller and memory ends over the link.
  Assumes package and interface compile first; power wait shortened to 50.
*/
`timescale 1ns/1ns
`default_nettype none
module dpu_bench;
  import dpu_pkg::*;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic ready, init_err, strobe_diff, burst_busy, burst_wr, burst_ap;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] burst_bank;
  logic [9:0] burst_col, col_last;
  int err_total, compares, n;
  logic [18:0] seen[$];
  // Rows: {command, bank, address mask, address value}
  logic [31:0] exp_seq[11] = '{{CMD_PRE, 2'h0, 13'h0400, 13'h0400},
    {CMD_MRS, BA_EMR2, 26'h0}, {CMD_MRS, BA_EMR3, 26'h0},
    {CMD_MRS, BA_EMR1, 13'h0781, 13'h0}, {CMD_MRS, BA_MR, 13'h0100, 13'h0100},
    {CMD_PRE, 2'h0, 13'h0400, 13'h0400}, {CMD_REF, 28'h0}, {CMD_REF, 28'h0},
    {CMD_MRS, BA_MR, 13'h0100, 13'h0}, {CMD_MRS, BA_EMR1, 13'h0380, 13'h0380},
    {CMD_MRS, BA_EMR1, 13'h0380, 13'h0}};
  int swap_ord[11] = '{0, 3, 4, 1, 2, 5, 6, 7, 8, 9, 10};
  // Rows: {address, read value, error}
  logic [40:0] reg_rows[5] = '{{REG_CTRL, 33'h0}, {REG_MODE, 32'h232, 1'b0},
    {REG_EMR, 33'h0}, {REG_STAT, 33'h0}, {8'h20, 33'h1}};
  dpu_link_if link();
  dpu_ctl #(.PWR_WAIT(50)) u_dpu_ctl (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  dpu_mem u_dpu_mem (.core_clk(core_clk), .reset(reset), .link(link), .ready(ready),
    .init_err(init_err), .strobe_diff(strobe_diff), .burst_busy(burst_busy),
    .burst_wr(burst_wr), .burst_bank(burst_bank), .burst_col(burst_col), .burst_ap(burst_ap));
  dpu_assertions u_dpu_assertions (.core_clk(core_clk), .reset(reset), .ck(link.ck),
    .ck_n(link.ck_n), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr), .odt(link.odt));
  // ----------------------------------------
  // Clock, link monitor, watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge link.ck) begin
    if (link.cke && {link.cs_n, link.ras_n, link.cas_n, link.we_n} !== CMD_NOP)
      seen.push_back({link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr});
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One order at a time: a second write while one is pending is dropped
  task automatic issue(input logic [31:0] w);
    apb(REG_CMD, 1'b1, w);
    do begin
      apb(REG_STAT, 1'b0, 32'h0);
    end while (rd[3] !== 1'b0);
  endtask
  task automatic run_init(input logic [31:0] ctrl);
    int j;
    seen.delete();
    apb(REG_CTRL, 1'b1, ctrl);
    n = 0;
    while (ready !== 1'b1 && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
    // Orders are refused until the controller reports done
    do begin
      apb(REG_STAT, 1'b0, 32'h0);
    end while (rd[1] !== 1'b1);
    chk("ready", 32'(ready), 32'h1);
    chk("count", seen.size(), 11);
    for (int i = 0; i < 11; i++) begin
      j = ctrl[CTRL_SWAP] ? swap_ord[i] : i;
      chk("cmd", 32'(seen[i][18:15]), 32'(exp_seq[j][31:28]));
      if (exp_seq[j][31:28] == CMD_MRS) chk("bank", 32'(seen[i][14:13]), 32'(exp_seq[j][27:26]));
      chk("addr", 32'(seen[i][12:0] & exp_seq[j][25:13]),
        32'(exp_seq[j][12:0] | ((j == 3 && ctrl[CTRL_SE]) ? 13'h0400 : 13'h0)));
    end
    chk("init err", 32'(init_err), 32'h0);
    chk("strobes", 32'(strobe_diff), 32'(!ctrl[CTRL_SE]));
  endtask
  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    foreach (reg_rows[i]) begin
      apb(reg_rows[i][40:33], 1'b0, 32'h0);
      chk("reg", rd, reg_rows[i][32:1]);
      chk("slverr", 32'(er), 32'(reg_rows[i][0]));
    end
    chk("cke", 32'(link.cke), 32'h0);
    chk("odt", 32'(link.odt), 32'h0);
    apb(REG_CMD, 1'b1, 32'h8000);
    apb(REG_STAT, 1'b0, 32'h0);
    chk("early order", rd & 32'h4, 32'h4);
    apb(REG_STAT, 1'b1, 32'h4);
    apb(REG_CTRL, 1'b1, 32'h1);
    repeat (100) @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    chk("cke in reset", 32'(link.cke), 32'h0);
    chk("ready in reset", 32'(ready), 32'h0);
    reset <= 1'b0;
    run_init(32'h7);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    run_init(32'h1);
    issue({14'h0, OP_ACT, 2'h1, 13'h0005});
    issue({14'h0, OP_RD, 2'h1, 13'h0408});
    n = 0;
    while (burst_busy !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk("burst bank", 32'(burst_bank), 32'h1);
    chk("burst col", 32'(burst_col), 32'h8);
    chk("burst ap", 32'({burst_ap, burst_wr}), 32'h2);
    while (burst_busy === 1'b1 && n < 900) begin
      col_last = burst_col;
      @(posedge core_clk);
      n++;
    end
    chk("last col", 32'(col_last), 32'hb);
    issue({14'h0, OP_RD, 2'h2, 13'h0});
    chk("closed bank", rd & 32'h4, 32'h4);
    give_verdict();
  end
endmodule
`default_nettype wire
